//--- hdl/program_sequencer.sv
// Program sequencer: pointer, return stack, table reads
// What this block does
// - Four phases per cycle, pointer steps at T1
// - Non-sequential transfers flush fetched instruction
// - Pointer advances one word otherwise
// - Only low pointer byte is software register
// - Jump, call, interrupt, reset load full address
// - Taken skip discards fetch, one dummy cycle
// - Sixteen-bit words, pointer width 12 or 13
// - Low byte write jumps within page
// - Low byte write inserts one dummy cycle
// - Stack holds pointers, hidden from software
// - Call or interrupt acknowledge pushes return
// - Returns pop and restore pointer
// - Reset leaves stack empty
// - Full stack holds interrupt until a return
// - Call on full stack drops oldest entry
// - ALU results update zero; carry only on add, subtract, rotate
// - Execution starts at word zero
// - Table address is high and low pointers
// - Standard reads sector zero, extended any sector
// - Low byte to memory, high byte to latch
// - Table reads clear unimplemented latch bits
// - Table reads take two cycles
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module program_sequencer #(
  parameter int IP_W   = 12,
  parameter int DEPTH  = seq_pkg::STACK_LEVELS,
  parameter int WORD_W = 16
) (
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire logic                  op_valid,
  input  wire seq_pkg::op_type       op_kind,
  input  wire logic [IP_W-1:0]       op_target,
  input  wire logic [7:0]            op_mem,
  input  wire logic [2:0]            op_sector,
  input  wire logic                  irq_req,
  input  wire logic [IP_W-1:0]       irq_vector,
  input  wire logic                  alu_en,
  input  wire seq_pkg::alu_type      alu_op,
  input  wire logic [7:0]            alu_a,
  input  wire logic [7:0]            alu_b,
  input  wire logic [2:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [WORD_W-1:0]     pmem_data,
  output logic [IP_W-1:0]            pmem_addr,
  output logic                       fetch_en,
  output logic                       dummy_cycle,
  output logic                       irq_ack,
  output logic                       interrupt_return_op_done,
  output logic                       tbl_wr,
  output logic [seq_pkg::DEST_W-1:0] tbl_dest,
  output logic [7:0]                 tbl_data,
  output logic [7:0]                 alu_res,
  output logic                       stack_full,
  output logic                       stack_empty,
  output logic [7:0]                 reg_rdata
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
  localparam logic [CW-1:0] CNT_ONE  = CW'(1);
  localparam logic [PW-1:0] PTR_ONE  = PW'(1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [IP_W-1:0] IP_ONE = IP_W'(1);
  // Implemented high bits of a program word
  localparam int HI_W = (WORD_W - 8 > 8) ? 8 : WORD_W - 8;
  localparam logic [7:0] HI_MASK = 8'((16'h1 << HI_W) - 16'h1);

  // Circular pointer step, used for push and pop
  function automatic logic [PW-1:0] ptr_step(input logic [PW-1:0] p,
                                              input logic up);
    if (up) begin
      ptr_step = (p == PTR_LAST) ? '0 : p + PTR_ONE;
    end else begin
      ptr_step = (p == '0) ? PTR_LAST : p - PTR_ONE;
    end
  endfunction

  // ****************************************
  // Phase and sequencing state
  // ****************************************
  logic [1:0]      phase_ff, nxt_phase;
  logic [IP_W-1:0] ip_ff, nxt_ip;
  logic [IP_W-1:0] paddr_ff, nxt_paddr;
  logic            fetch_ff, nxt_fetch;
  logic            dummy_ff, nxt_dummy;
  logic            tbusy_ff, nxt_tbusy;
  logic            txt_ff, nxt_txt;
  logic [7:0]      tmem_ff, nxt_tmem;
  logic [2:0]      tsec_ff, nxt_tsec;
  logic            ack_ff, nxt_ack;
  logic            retd_ff, nxt_retd;
  logic            twr_ff, nxt_twr;
  logic [seq_pkg::DEST_W-1:0] tdest_ff, nxt_tdest;
  logic [7:0]      tdata_ff, nxt_tdata;
  logic            plw_ff, nxt_plw;
  logic [7:0]      plv_ff, nxt_plv;
  logic [7:0]      tblp_ff, nxt_tblp;
  logic [7:0]      tbhp_ff, nxt_tbhp;
  logic [7:0]      table_high_latch_ff, nxt_table_high_latch;
  logic [7:0]      stat_ff, nxt_stat;
  logic [7:0]      ares_ff, nxt_ares;
  logic [7:0]      rdata_ff, nxt_rdata;
  logic [PW-1:0]   sp_ff, nxt_sp;
  logic [CW-1:0]   cnt_ff, nxt_cnt;
  logic [IP_W-1:0] stack_mem [DEPTH];
  logic            push;
  logic [IP_W-1:0] push_val;
  logic            t1, t4;
  logic [15:0]     taddr;
  logic [8:0]      sum;

  assign t1    = (phase_ff == seq_pkg::PH_T1);
  assign t4    = (phase_ff == seq_pkg::PH_T4);
  assign taddr = {tbhp_ff, tblp_ff};

  // Next-state logic for the whole sequencer
  always_comb begin
    nxt_phase = phase_ff + 2'h1;
    nxt_ip    = ip_ff;
    nxt_paddr = paddr_ff;
    nxt_fetch = 1'b0;
    nxt_dummy = dummy_ff;
    nxt_tbusy = tbusy_ff;
    nxt_txt   = txt_ff;
    nxt_tmem  = tmem_ff;
    nxt_tsec  = tsec_ff;
    nxt_ack   = 1'b0;
    nxt_retd  = 1'b0;
    nxt_twr   = 1'b0;
    nxt_tdest = tdest_ff;
    nxt_tdata = tdata_ff;
    nxt_plw   = plw_ff;
    nxt_plv   = plv_ff;
    nxt_tblp  = tblp_ff;
    nxt_tbhp  = tbhp_ff;
    nxt_table_high_latch  = table_high_latch_ff;
    nxt_stat  = stat_ff;
    nxt_ares  = ares_ff;
    nxt_rdata = rdata_ff;
    nxt_sp    = sp_ff;
    nxt_cnt   = cnt_ff;
    push      = 1'b0;
    push_val  = ip_ff - IP_ONE;
    sum       = 9'h000;
    // Software writes; the low byte waits for a T4 with no table read, dummy cycle, op or interrupt
    if (reg_wr) begin
      case (reg_addr)
        seq_pkg::OFS_IPL: begin
          nxt_plw = 1'b1;
          nxt_plv = reg_wdata;
        end
        seq_pkg::OFS_TBLP: nxt_tblp = reg_wdata;
        seq_pkg::OFS_TBHP: nxt_tbhp = reg_wdata;
        seq_pkg::OFS_TABLE_HIGH_LATCH: nxt_table_high_latch = reg_wdata;
        seq_pkg::OFS_STAT: nxt_stat = reg_wdata;
        default: ;
      endcase
    end
    // Read data one cycle after the strobe; stack is not mapped
    if (reg_rd) begin
      case (reg_addr)
        seq_pkg::OFS_IPL:  nxt_rdata = ip_ff[7:0];
        seq_pkg::OFS_TBLP: nxt_rdata = tblp_ff;
        seq_pkg::OFS_TBHP: nxt_rdata = tbhp_ff;
        seq_pkg::OFS_TABLE_HIGH_LATCH: nxt_rdata = table_high_latch_ff;
        seq_pkg::OFS_STAT: nxt_rdata = stat_ff;
        default:           nxt_rdata = seq_pkg::BYTE_RST;
      endcase
    end
    // ALU status update, carry and zero
    if (alu_en) begin
      case (alu_op)
        seq_pkg::ALU_ADD: sum = {1'b0, alu_a} + {1'b0, alu_b};
        seq_pkg::ALU_SUB: sum = {1'b1, alu_a} - {1'b0, alu_b};
        seq_pkg::ALU_AND: sum = {stat_ff[seq_pkg::STAT_C], alu_a & alu_b};
        seq_pkg::ALU_RLC: sum = {alu_a, stat_ff[seq_pkg::STAT_C]};
        seq_pkg::ALU_INC: sum = {stat_ff[seq_pkg::STAT_C], alu_a + 8'h01};
        seq_pkg::ALU_DEC: sum = {stat_ff[seq_pkg::STAT_C], alu_a - 8'h01};
        default:          sum = {stat_ff[seq_pkg::STAT_C], alu_a};
      endcase
      nxt_ares = sum[7:0];
      nxt_stat[seq_pkg::STAT_C] = sum[8];
      nxt_stat[seq_pkg::STAT_Z] = (sum[7:0] == 8'h00);
    end
    // T1: fetch at the pointer, or the table word instead
    if (t1) begin
      if (tbusy_ff) begin
        nxt_paddr = taddr[IP_W-1:0];
      end else begin
        nxt_paddr = ip_ff;
        nxt_ip    = ip_ff + IP_ONE;
        nxt_fetch = 1'b1;
      end
    end
    // T4: finish the table read or execute the decoded class
    if (t4) begin
      if (tbusy_ff) begin
        nxt_tbusy = 1'b0;
        nxt_dummy = 1'b0;
        nxt_twr   = 1'b1;
        nxt_tdata = pmem_data[7:0];
        nxt_table_high_latch  = 8'(pmem_data[HI_W+7:8]) & HI_MASK;
        nxt_tdest = txt_ff ? {tsec_ff, tmem_ff}
                           : {3'h0, tmem_ff};
      end else if (dummy_ff) begin
        nxt_dummy = 1'b0;
      end else if (op_valid && op_kind != seq_pkg::OP_SEQ) begin
        nxt_dummy = 1'b1;
        case (op_kind)
          seq_pkg::OP_JUMP: nxt_ip = op_target;
          seq_pkg::OP_CALL: begin
            nxt_ip = op_target;
            push   = 1'b1;
          end
          seq_pkg::OP_RET, seq_pkg::OP_INTERRUPT_RETURN_OP: begin
            nxt_ip   = stack_mem[ptr_step(sp_ff, 1'b0)];
            nxt_sp   = ptr_step(sp_ff, 1'b0);
            nxt_cnt  = (cnt_ff == '0) ? cnt_ff : cnt_ff - CNT_ONE;
            nxt_retd = (op_kind == seq_pkg::OP_INTERRUPT_RETURN_OP);
          end
          seq_pkg::OP_SKIP: nxt_dummy = 1'b1;
          seq_pkg::OP_TREAD, seq_pkg::OP_XTREAD: begin
            nxt_tbusy = 1'b1;
            nxt_dummy = 1'b1;
            nxt_txt   = (op_kind == seq_pkg::OP_XTREAD);
            nxt_tmem  = op_mem;
            nxt_tsec  = op_sector;
          end
          default: nxt_dummy = 1'b0;
        endcase
      end else if (irq_req && cnt_ff != CNT_FULL) begin
        nxt_ip    = irq_vector;
        nxt_ack   = 1'b1;
        nxt_dummy = 1'b1;
        push      = 1'b1;
      end else if (plw_ff) begin
        nxt_ip    = {ip_ff[IP_W-1:8], plv_ff};
        // A fresh low-byte write in this very cycle stays pending
        nxt_plw   = reg_wr && (reg_addr == seq_pkg::OFS_IPL);
        nxt_dummy = 1'b1;
      end
    end
    // Push overwrites the oldest slot when full
    if (push) begin
      nxt_sp  = ptr_step(sp_ff, 1'b1);
      nxt_cnt = (cnt_ff == CNT_FULL) ? cnt_ff : cnt_ff + CNT_ONE;
    end
  end

  // Registers; reset starts at word zero with an empty stack
  always_ff @(posedge clk) begin
    if (srst) begin
      phase_ff <= seq_pkg::PH_T1;
      ip_ff    <= IP_W'(seq_pkg::RESET_VEC);
      paddr_ff <= IP_W'(seq_pkg::RESET_VEC);
      fetch_ff <= 1'b0;
      dummy_ff <= 1'b0;
      tbusy_ff <= 1'b0;
      txt_ff   <= 1'b0;
      tmem_ff  <= seq_pkg::BYTE_RST;
      tsec_ff  <= 3'h0;
      ack_ff   <= 1'b0;
      retd_ff  <= 1'b0;
      twr_ff   <= 1'b0;
      tdest_ff <= '0;
      tdata_ff <= seq_pkg::BYTE_RST;
      plw_ff   <= 1'b0;
      plv_ff   <= seq_pkg::BYTE_RST;
      tblp_ff  <= seq_pkg::BYTE_RST;
      tbhp_ff  <= seq_pkg::BYTE_RST;
      table_high_latch_ff  <= seq_pkg::BYTE_RST;
      stat_ff  <= seq_pkg::BYTE_RST;
      ares_ff  <= seq_pkg::BYTE_RST;
      rdata_ff <= seq_pkg::BYTE_RST;
      sp_ff    <= '0;
      cnt_ff   <= '0;
    end else begin
      phase_ff <= nxt_phase;
      ip_ff    <= nxt_ip;
      paddr_ff <= nxt_paddr;
      fetch_ff <= nxt_fetch;
      dummy_ff <= nxt_dummy;
      tbusy_ff <= nxt_tbusy;
      txt_ff   <= nxt_txt;
      tmem_ff  <= nxt_tmem;
      tsec_ff  <= nxt_tsec;
      ack_ff   <= nxt_ack;
      retd_ff  <= nxt_retd;
      twr_ff   <= nxt_twr;
      tdest_ff <= nxt_tdest;
      tdata_ff <= nxt_tdata;
      plw_ff   <= nxt_plw;
      plv_ff   <= nxt_plv;
      tblp_ff  <= nxt_tblp;
      tbhp_ff  <= nxt_tbhp;
      table_high_latch_ff  <= nxt_table_high_latch;
      stat_ff  <= nxt_stat;
      ares_ff  <= nxt_ares;
      rdata_ff <= nxt_rdata;
      sp_ff    <= nxt_sp;
      cnt_ff   <= nxt_cnt;
    end
  end

  // Stack storage has no reset; empty count guards it
  always_ff @(posedge clk) begin
    if (!srst && push) begin
      stack_mem[sp_ff] <= push_val;
    end
  end

  assign pmem_addr   = paddr_ff;
  assign fetch_en    = fetch_ff;
  assign dummy_cycle = dummy_ff;
  assign irq_ack     = ack_ff;
  assign interrupt_return_op_done   = retd_ff;
  assign tbl_wr      = twr_ff;
  assign tbl_dest    = tdest_ff;
  assign tbl_data    = tdata_ff;
  assign alu_res     = ares_ff;
  assign reg_rdata   = rdata_ff;
  assign stack_full  = (cnt_ff == CNT_FULL);
  assign stack_empty = (cnt_ff == '0);

  // ****************************************
  // Checks
  // ****************************************
  chk_phase_wrap: assert property (@(posedge clk) disable iff (srst)
    t4 |=> t1) else $error("phase did not wrap");
  chk_fetch_step: assert property (@(posedge clk) disable iff (srst)
    fetch_en |-> pmem_addr == ip_ff - IP_ONE)
    else $error("fetch did not step pointer");
  chk_jump_load: assert property (@(posedge clk) disable iff (srst)
    (t4 && !tbusy_ff && !dummy_ff && op_valid && op_kind == seq_pkg::OP_JUMP)
    |=> ip_ff == $past(op_target) && dummy_cycle)
    else $error("jump target not loaded");
  chk_skip_dummy: assert property (@(posedge clk) disable iff (srst)
    (t4 && !tbusy_ff && !dummy_ff && op_valid && op_kind == seq_pkg::OP_SKIP)
    |=> dummy_cycle [*4] ##1 !dummy_cycle)
    else $error("skip dummy cycle wrong length");
  chk_ipl_page: assert property (@(posedge clk) disable iff (srst)
    (t4 && plw_ff && !nxt_ack && !dummy_ff && !tbusy_ff && !op_valid)
    |=> ip_ff[IP_W-1:8] == $past(ip_ff[IP_W-1:8]) && dummy_cycle)
    else $error("low byte write left page");
  chk_full_hold: assert property (@(posedge clk) disable iff (srst)
    stack_full |=> !irq_ack) else $error("interrupt taken on full stack");
  chk_table_two: assert property (@(posedge clk) disable iff (srst)
    (t4 && !tbusy_ff && !dummy_ff && op_valid && op_kind == seq_pkg::OP_TREAD)
    |=> !tbl_wr [*4] ##1 tbl_wr)
    else $error("table read not two cycles");
  chk_latch_mask: assert property (@(posedge clk) disable iff (srst)
    tbl_wr |-> (table_high_latch_ff & ~HI_MASK) == 8'h00)
    else $error("unused latch bits set");
  chk_std_sector: assert property (@(posedge clk) disable iff (srst)
    (tbl_wr && !txt_ff) |-> tbl_dest[seq_pkg::DEST_W-1:8] == 3'h0)
    else $error("standard read left sector zero");
  chk_ret_pop: assert property (@(posedge clk) disable iff (srst)
    (t4 && !tbusy_ff && !dummy_ff && op_valid && op_kind == seq_pkg::OP_RET
     && !stack_empty) |=> cnt_ff == $past(cnt_ff) - CNT_ONE)
    else $error("return did not pop");
endmodule
`default_nettype wire

//--- hdl/seq_pkg.sv
// Shared constants and types for the program sequencer
package seq_pkg;
  // Register offsets on the plain port
  localparam logic [2:0] OFS_IPL  = 3'h0;
  localparam logic [2:0] OFS_TBLP = 3'h1;
  localparam logic [2:0] OFS_TBHP = 3'h2;
  localparam logic [2:0] OFS_TABLE_HIGH_LATCH = 3'h3;
  localparam logic [2:0] OFS_STAT = 3'h4;
  // Status bit positions
  localparam int STAT_C = 0;
  localparam int STAT_Z = 1;
  // Phases of one instruction cycle
  localparam logic [1:0] PH_T1 = 2'h0;
  localparam logic [1:0] PH_T4 = 2'h3;
  // Reset vector and reset values
  localparam logic [15:0] RESET_VEC = 16'h0000;
  localparam logic [7:0]  BYTE_RST  = 8'h00;
  localparam int STACK_LEVELS = 8;
  localparam int DEST_W       = 11;
  // Execution classes from the decoder
  typedef enum logic [2:0] {
    OP_SEQ, OP_JUMP, OP_CALL, OP_RET,
    OP_INTERRUPT_RETURN_OP, OP_SKIP, OP_TREAD, OP_XTREAD
  } op_type;
  typedef enum logic [2:0] {
    ALU_ADD, ALU_SUB, ALU_AND, ALU_RLC,
    ALU_INC, ALU_DEC
  } alu_type;
endpackage

//--- tb/pmem_model.sv
// Program memory model standing on the far side of the fetch port
`timescale 1ns/1ps
`default_nettype none
module pmem_model #(
  parameter int AW = 12,
  parameter int WW = 16
) (
  input  wire logic [AW-1:0] addr,
  output logic      [WW-1:0] data
);
  // Content derived from the address, so neighbouring words never match
  function automatic logic [WW-1:0] word(input logic [AW-1:0] a);
    return WW'({a[7:0] ^ 8'h3c, a[7:0] ^ 8'hc3});
  endfunction

  // Any word is reachable by fetch or table address
  assign data = word(addr);
endmodule
`default_nettype wire

//--- tb/program_sequencer_tb.sv
// Self-checking bench for the program sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch t=%0t got %h exp %h", $time, (g), (e)); end end
module program_sequencer_tb;
  localparam int IW = 12;
  localparam int WW = 14; // Narrow word so some latch bits are unimplemented
  logic                   clk        = 1'b0;
  logic                   srst       = 1'b1;
  logic                   op_valid   = 1'b0;
  seq_pkg::op_type        op_kind    = seq_pkg::OP_SEQ;
  logic [IW-1:0]          op_target  = 12'h000;
  logic [7:0]             op_mem     = 8'h91;
  logic [2:0]             op_sector  = 3'h6; // Nonzero so a standard read must drop it
  logic                   irq_req    = 1'b0;
  logic [IW-1:0]          irq_vector = 12'h0c4;
  logic                   alu_en     = 1'b0;
  seq_pkg::alu_type       alu_op     = seq_pkg::ALU_ADD;
  logic [7:0]             alu_a      = 8'h00;
  logic [7:0]             alu_b      = 8'h00;
  logic [2:0]             reg_addr   = 3'h0;
  logic [7:0]             reg_wdata  = 8'h00;
  logic                   reg_wr     = 1'b0;
  logic                   reg_rd     = 1'b0;
  logic [WW-1:0]          pmem_data;
  logic [IW-1:0]          pmem_addr;
  logic                   fetch_en;
  logic                   dummy_cycle;
  logic                   irq_ack;
  logic                   interrupt_return_op_done;
  logic                   tbl_wr;
  logic [10:0]            tbl_dest;
  logic [7:0]             tbl_data;
  logic [7:0]             alu_res;
  logic                   stack_full;
  logic                   stack_empty;
  logic [7:0]             reg_rdata;
  int                     n_errors   = 0;
  int                     checks     = 0;
  int                     acks       = 0;
  int                     retis      = 0;

  program_sequencer #(.IP_W(IW), .DEPTH(8), .WORD_W(WW)) u_program_sequencer (
    .clk(clk), .srst(srst), .op_valid(op_valid), .op_kind(op_kind), .op_target(op_target),
    .op_mem(op_mem), .op_sector(op_sector), .irq_req(irq_req), .irq_vector(irq_vector),
    .alu_en(alu_en), .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .pmem_data(pmem_data),
    .pmem_addr(pmem_addr), .fetch_en(fetch_en), .dummy_cycle(dummy_cycle), .irq_ack(irq_ack),
    .interrupt_return_op_done(interrupt_return_op_done), .tbl_wr(tbl_wr), .tbl_dest(tbl_dest), .tbl_data(tbl_data),
    .alu_res(alu_res), .stack_full(stack_full), .stack_empty(stack_empty), .reg_rdata(reg_rdata));

  pmem_model #(.AW(IW), .WW(WW)) u_pmem_model (.addr(pmem_addr), .data(pmem_data));

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // Pulse counters, sampled mid-cycle where outputs have settled
  always @(negedge clk) begin
    if (irq_ack === 1'b1) acks++;
    if (interrupt_return_op_done === 1'b1) retis++;
  end

  // ************************************************************
  // Access tasks
  // ************************************************************
  // Register write: one strobe cycle
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Register read: data stands from the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask

  // Next instruction fetch: address and whether it lands in a dummy cycle
  task automatic nxt(output logic [IW-1:0] a, output logic d);
    int n;
    n = 0;
    @(negedge clk);
    while (fetch_en !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (n >= 40) n_errors++;
    a = pmem_addr;
    d = dummy_cycle;
  endtask

  // Issue one op at the T4 edge of a real (non-dummy) instruction cycle
  task automatic exec(input seq_pkg::op_type k, input logic [IW-1:0] t, output logic [IW-1:0] f);
    int n;
    n = 0;
    @(negedge clk);
    while (!(fetch_en === 1'b1 && dummy_cycle === 1'b0) && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (n >= 40) n_errors++;
    f = pmem_addr;
    repeat (2) @(posedge clk);
    op_valid <= 1'b1;
    op_kind <= k;
    op_target <= t;
    @(posedge clk);
    op_valid <= 1'b0;
  endtask

  // Table read: address on the fetch port, write-back three clocks later
  task automatic tread(input seq_pkg::op_type k, input logic [IW-1:0] ta, input logic [10:0] dst);
    logic [IW-1:0] f;
    logic [7:0]    r;
    logic [WW-1:0] w;
    w = u_pmem_model.word(ta);
    // Latch preset to ones, so the cleared upper bits are visible
    wr(seq_pkg::OFS_TABLE_HIGH_LATCH, 8'hff);
    exec(k, 12'h000, f);
    // Table address goes out at the following T1 edge
    @(posedge clk);
    @(negedge clk);
    `CHK({pmem_addr, fetch_en}, {ta, 1'b0})
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK({tbl_wr, tbl_dest, tbl_data}, {1'b1, dst, w[7:0]})
    rd(seq_pkg::OFS_TABLE_HIGH_LATCH, r);
    `CHK(r, {2'b00, w[13:8]})
  endtask

  // ALU result registered one cycle after the strobe
  task automatic alu(input seq_pkg::alu_type o, input logic [7:0] a, input logic [7:0] b, input logic [7:0] e);
    @(posedge clk);
    alu_en <= 1'b1;
    alu_op <= o;
    alu_a <= a;
    alu_b <= b;
    @(posedge clk);
    alu_en <= 1'b0;
    @(negedge clk);
    `CHK(alu_res, e)
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    logic [IW-1:0] f;
    logic [IW-1:0] a;
    logic [IW-1:0] stk[$];
    logic          d;
    logic [7:0]    r;
    int            n;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    nxt(a, d);
    `CHK(a, 12'h000)
    `CHK(stack_empty, 1'b1)
    for (int i = 1; i < 6; i++) begin
      rd(3'(i), r);
      `CHK(r, 8'h00)
    end
    $display("test reset done");
    exec(seq_pkg::OP_SEQ, 12'h000, f);
    nxt(a, d);
    `CHK({a, d}, {f + 12'h001, 1'b0})
    exec(seq_pkg::OP_JUMP, 12'h3a5, f);
    nxt(a, d);
    `CHK({a, d}, {12'h3a5, 1'b1})
    exec(seq_pkg::OP_SKIP, 12'h000, f);
    nxt(a, d);
    `CHK({a, d}, {f + 12'h001, 1'b1})
    nxt(f, d);
    wr(seq_pkg::OFS_IPL, 8'h40);
    nxt(a, d);
    `CHK({a, d}, {f[11:8], 8'h40, 1'b1})
    $display("test flow done");
    wr(seq_pkg::OFS_TBLP, 8'h06);
    wr(seq_pkg::OFS_TBHP, 8'h0f);
    rd(seq_pkg::OFS_TBHP, r);
    `CHK(r, 8'h0f)
    tread(seq_pkg::OP_TREAD, 12'hf06, {3'h0, 8'h91});
    wr(seq_pkg::OFS_TBLP, 8'h05);
    op_sector <= 3'h5;
    op_mem <= 8'h22;
    tread(seq_pkg::OP_XTREAD, 12'hf05, {3'h5, 8'h22});
    wr(seq_pkg::OFS_TABLE_HIGH_LATCH, 8'h5c);
    rd(seq_pkg::OFS_TABLE_HIGH_LATCH, r);
    `CHK(r, 8'h5c)
    $display("test table done");
    // Nine calls on an eight-deep stack: the oldest return is lost
    for (int i = 0; i < 9; i++) begin
      exec(seq_pkg::OP_CALL, 12'h100 + 12'(i * 32), f);
      stk.push_back(f);
      nxt(a, d);
      `CHK(a, 12'h100 + 12'(i * 32))
      if (i == 7) `CHK(stack_full, 1'b1)
    end
    void'(stk.pop_front());
    @(posedge clk);
    irq_req <= 1'b1;
    exec(seq_pkg::OP_SEQ, 12'h000, f);
    exec(seq_pkg::OP_SEQ, 12'h000, f);
    `CHK(acks, 0)
    exec(seq_pkg::OP_RET, 12'h000, f);
    nxt(a, d);
    `CHK(a, stk.pop_back())
    n = 0;
    while (acks == 0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    irq_req <= 1'b0;
    nxt(a, d);
    `CHK({acks, a}, {32'd1, 12'h0c4})
    exec(seq_pkg::OP_INTERRUPT_RETURN_OP, 12'h000, f);
    repeat (6) @(posedge clk);
    `CHK(retis, 1)
    for (int i = 0; i < 7; i++) begin
      exec(seq_pkg::OP_RET, 12'h000, f);
      nxt(a, d);
      `CHK(a, stk.pop_back())
    end
    `CHK(stack_empty, 1'b1)
    $display("test stack done");
    alu(seq_pkg::ALU_ADD, 8'hff, 8'h01, 8'h00);
    rd(seq_pkg::OFS_STAT, r);
    `CHK(r[1:0], 2'b11)
    alu(seq_pkg::ALU_SUB, 8'h09, 8'h04, 8'h05);
    alu(seq_pkg::ALU_AND, 8'hf0, 8'h3c, 8'h30);
    alu(seq_pkg::ALU_INC, 8'h7f, 8'h00, 8'h80);
    alu(seq_pkg::ALU_DEC, 8'h00, 8'h00, 8'hff);
    alu(seq_pkg::ALU_RLC, 8'h81, 8'h00, 8'h03);
    rd(seq_pkg::OFS_STAT, r);
    `CHK(r[1:0], 2'b01)
    $display("test alu done");
    print_verdict();
  end

  // Watchdog well beyond the few hundred clocks the tests need
  initial begin
    #(25 * 20000);
    n_errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
